//--- dual_channel_pwm_unit.sv
// The Wishbone slave port and the register addresses were decided locally.
`include "pulse_map.svh"

// What this block does
// - Two independent pulse channels A and B, 8-bit duty in normal mode.
// - Each period counter advances on its channel's prescaled oscillator clock.
// - Writing one to a channel enable bit starts its pulse output, except channel B in wide mode, which stays parked.
// - A disabled channel leaves its pin undriven, high impedance.
// - Prescale code 0 divides by 2, each step doubles, code 7 divides by 256.
// - Narrow mode period is 256 prescaled clocks.
// - Wide mode period is 65536 prescaled clocks.
// - Width select bit: zero gives 8-bit, one gives 16-bit operation.
// - Wide mode duty: channel B register high byte, channel A low byte.
// - Wide mode waveform appears only on channel A.
// - Narrow mode channel A duty is its register over 256.
// - Narrow mode channel B duty is its register over 256.
// - Wide mode duty is the joined value over 65536.
// - Channel B drives port two bit zero as alternate function.
// - Channel A drives port three bit six as alternate function.
// - Width select register bit 7 holds low voltage reset enable, kept separately.
module dual_channel_pwm_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic port_three_bit_six_o,
  output logic port_three_bit_six_oe_n_o,
  output logic port_two_bit_zero_o,
  output logic port_two_bit_zero_oe_n_o,
  output logic low_voltage_reset_enable_o
);
  import pulse_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bus_state_e bus_q, bus_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  byte_t control_main_q, control_main_d;
  byte_t width_select_q, width_select_d;
  byte_t duty_a_q, duty_a_d;
  byte_t duty_b_q, duty_b_d;
  reg_idx_t idx;
  byte_t wbyte;
  logic wr_low;

  logic channel_a_enable, channel_b_enable;
  prescale_t channel_a_prescale, channel_b_prescale;
  logic wide_mode;
  logic run_a, run_b;
  logic tick_a, tick_b;
  logic level_a, level_b;
  duty_t duty_for_a, duty_for_b;

  logic pin_a_q, pin_a_d;
  logic pin_a_oe_n_q, pin_a_oe_n_d;
  logic pin_b_q, pin_b_d;
  logic pin_b_oe_n_q, pin_b_oe_n_d;
  logic lvr_q, lvr_d;

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************

  // Decode the word index and the low byte lane
  assign idx = wb_adr_i[`ADR_IDX_MSB:`ADR_IDX_LSB];
  assign wbyte = wb_dat_i[7:0];
  assign wr_low = wb_we_i && wb_sel_i[`SEL_LANE_LOW];

  // One-cycle ack; writes commit on the edge that raises ack
  always_comb begin
    bus_d = bus_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    control_main_d = control_main_q;
    width_select_d = width_select_q;
    duty_a_d = duty_a_q;
    duty_b_d = duty_b_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_d = BUS_ACK;
          ack_d = 1'b1;
          rdata_d = `RD_ZERO;
          unique case (idx)
            `IDX_CONTROL_MAIN: begin
              rdata_d[7:0] = control_main_q;
              if (wr_low) begin
                control_main_d = wbyte;
              end
            end
            `IDX_WIDTH_SELECT: begin
              rdata_d[7:0] = width_select_q;
              if (wr_low) begin
                // Only mode and low voltage reset bits exist; others read zero
                width_select_d = wbyte & `WSEL_MASK;
              end
            end
            `IDX_DUTY_A: begin
              rdata_d[7:0] = duty_a_q;
              if (wr_low) begin
                duty_a_d = wbyte;
              end
            end
            `IDX_DUTY_B: begin
              rdata_d[7:0] = duty_b_q;
              if (wr_low) begin
                duty_b_d = wbyte;
              end
            end
            default: begin
              rdata_d = `RD_ZERO; // Unmapped: acked, reads zero, writes dropped
            end
          endcase
        end
      end
      BUS_ACK: begin
        // Gap cycle keeps a still-held strobe from being taken twice
        bus_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      ack_q <= 1'b0;
      rdata_q <= `RD_ZERO;
      control_main_q <= `RST_CONTROL_MAIN;
      width_select_q <= `RST_WIDTH_SELECT;
      duty_a_q <= `RST_DUTY;
      duty_b_q <= `RST_DUTY;
    end else begin
      bus_q <= bus_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      control_main_q <= control_main_d;
      width_select_q <= width_select_d;
      duty_a_q <= duty_a_d;
      duty_b_q <= duty_b_d;
    end
  end

  // ****************************************************************
  // Field extraction and mode steering
  // ****************************************************************

  // Control fields for both channels
  assign channel_a_enable = control_main_q[`CTL_A_EN];
  assign channel_b_enable = control_main_q[`CTL_B_EN];
  assign channel_a_prescale = control_main_q[`CTL_A_PS_MSB:`CTL_A_PS_LSB];
  assign channel_b_prescale = control_main_q[`CTL_B_PS_MSB:`CTL_B_PS_LSB];
  assign wide_mode = width_select_q[`WSEL_MODE];

  // Channel B is parked in wide mode since its register feeds the high byte
  assign run_a = channel_a_enable;
  assign run_b = channel_b_enable && !wide_mode;
  assign duty_for_a = wide_mode ? {duty_b_q, duty_a_q} : {8'h00, duty_a_q};
  assign duty_for_b = {8'h00, duty_b_q};

  // ****************************************************************
  // Channel engines
  // ****************************************************************

  // Prescaler and period counter for channel A
  prescale_divider u_div_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_a),
    .ratio_i(channel_a_prescale),
    .tick_o(tick_a)
  );

  pwm_period_channel u_chan_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_a),
    .tick_i(tick_a),
    .wide_i(wide_mode),
    .duty_i(duty_for_a),
    .level_o(level_a)
  );

  // Channel B always counts the narrow period
  prescale_divider u_div_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_b),
    .ratio_i(channel_b_prescale),
    .tick_o(tick_b)
  );

  pwm_period_channel u_chan_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_b),
    .tick_i(tick_b),
    .wide_i(1'b0),
    .duty_i(duty_for_b),
    .level_o(level_b)
  );

  // ****************************************************************
  // Pin drivers
  // ****************************************************************

  // Enables are active low; a stopped channel floats its pin
  always_comb begin
    pin_a_d = run_a && level_a;
    pin_a_oe_n_d = !run_a;
    pin_b_d = run_b && level_b;
    pin_b_oe_n_d = !run_b;
    lvr_d = width_select_q[`WSEL_LVR];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_q <= 1'b0;
      pin_a_oe_n_q <= 1'b1;
      pin_b_q <= 1'b0;
      pin_b_oe_n_q <= 1'b1;
      lvr_q <= 1'b0;
    end else begin
      pin_a_q <= pin_a_d;
      pin_a_oe_n_q <= pin_a_oe_n_d;
      pin_b_q <= pin_b_d;
      pin_b_oe_n_q <= pin_b_oe_n_d;
      lvr_q <= lvr_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign port_three_bit_six_o = pin_a_q;
  assign port_three_bit_six_oe_n_o = pin_a_oe_n_q;
  assign port_two_bit_zero_o = pin_b_q;
  assign port_two_bit_zero_oe_n_o = pin_b_oe_n_q;
  assign low_voltage_reset_enable_o = lvr_q;
endmodule

//--- pulse_map.svh
`ifndef PULSE_MAP_SVH
`define PULSE_MAP_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define IDX_CONTROL_MAIN 6'h25
`define IDX_DUTY_A 6'h26
`define IDX_DUTY_B 6'h27
`define IDX_WIDTH_SELECT 6'h2b
`define ADR_IDX_MSB 7
`define ADR_IDX_LSB 2
`define SEL_LANE_LOW 0

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_A_PS_LSB 0
`define CTL_A_PS_MSB 2
`define CTL_A_EN 3
`define CTL_B_PS_LSB 4
`define CTL_B_PS_MSB 6
`define CTL_B_EN 7
`define WSEL_MODE 0
`define WSEL_LVR 7
`define WSEL_MASK 8'h81

// ****************************************************************
// Reset values and counting limits
// ****************************************************************
`define RST_CONTROL_MAIN 8'h00
`define RST_WIDTH_SELECT 8'h00
`define RST_DUTY 8'h00
`define RD_ZERO 32'h00000000
`define PRESCALE_FULL 8'hff
`define PRESCALE_TOP_CODE 3'h7
`define PERIOD_LAST_NARROW 16'h00ff
`define PERIOD_LAST_WIDE 16'hffff

`endif

//--- pulse_pkg.sv
package pulse_pkg;

  // ****************************************************************
  // Shared types
  // ****************************************************************
  typedef logic [7:0] byte_t;
  typedef logic [2:0] prescale_t;
  typedef logic [15:0] duty_t;
  typedef logic [5:0] reg_idx_t;

  // Bus slave handshake phases
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

endpackage

//--- prescale_divider.sv
`include "pulse_map.svh"

module prescale_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire pulse_pkg::prescale_t ratio_i,
  output logic tick_o
);
  import pulse_pkg::*;

  byte_t count_q, count_d;
  byte_t last;
  logic tick_q, tick_d;

  // Divide by two to the power ratio plus one; idle divider stays cleared
  always_comb begin
    last = `PRESCALE_FULL >> (`PRESCALE_TOP_CODE - ratio_i);
    count_d = count_q + 8'h01;
    tick_d = 1'b0;
    if (!run_i) begin
      count_d = 8'h00;
    end else if (count_q >= last) begin
      count_d = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule

//--- pwm_period_channel.sv
`include "pulse_map.svh"

module pwm_period_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic wide_i,
  input wire pulse_pkg::duty_t duty_i,
  output logic level_o
);
  import pulse_pkg::*;

  duty_t count_q, count_d;
  duty_t shadow_q, shadow_d;
  duty_t last;
  logic level_q, level_d;

  // Period counter with duty shadow reloaded at the wrap and while stopped
  always_comb begin
    last = wide_i ? `PERIOD_LAST_WIDE : `PERIOD_LAST_NARROW;
    count_d = count_q;
    shadow_d = shadow_q;
    if (!run_i) begin
      count_d = 16'h0000;
      shadow_d = duty_i;
    end else if (tick_i) begin
      // Greater-or-equal catches a count left high by a mode change
      if (count_q >= last) begin
        count_d = 16'h0000;
        shadow_d = duty_i;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
    level_d = run_i && (count_d < shadow_d);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
      shadow_q <= 16'h0000;
      level_q <= 1'b0;
    end else begin
      count_q <= count_d;
      shadow_q <= shadow_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
endmodule

//--- pin_load.sv
// ****************************************************************
// Pin load: pulled-up port pin seen from outside
// ****************************************************************
module pin_load (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic drv_i,
  input wire logic oe_n_i,
  output logic level_o,
  output int highs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin floats up to the pull-up, never to the last level
  assign level_o = oe_n_i ? 1'b1 : drv_i;
  // Counts driven-high cycles; the clearing cycle still counts itself
  always_ff @(posedge clk_i) begin
    highs_o <= (clr_i ? 0 : highs_o) + int'(!oe_n_i && drv_i);
  end
endmodule

//--- pwm_properties.sv
// ****************************************************************
// Port checker for the pulse unit
// ****************************************************************
module pwm_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic port_three_bit_six_o,
  input wire logic port_three_bit_six_oe_n_o,
  input wire logic port_two_bit_zero_o,
  input wire logic port_two_bit_zero_oe_n_o,
  input wire logic low_voltage_reset_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  // Request level; the taking edge is its rise
  assign req = wb_cyc_i & wb_stb_i;
  sequence wr_at(logic [7:0] a);
    $rose(req) && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_answer: assert property ($rose(req) |=> wb_ack_o) else $error("ack missing");
  chk_ack_cause: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_off_low_a: assert property (port_three_bit_six_oe_n_o |-> !port_three_bit_six_o)
    else $error("released pin A driven");
  chk_off_low_b: assert property (port_two_bit_zero_oe_n_o |-> !port_two_bit_zero_o)
    else $error("released pin B driven");
  chk_enable_a: assert property (wr_at(8'h94) |-> ##2
    port_three_bit_six_oe_n_o == !$past(wb_dat_i[3], 2)) else $error("pin A enable wrong");
  chk_disable_b: assert property (wr_at(8'h94) ##0 !wb_dat_i[7] |-> ##2
    port_two_bit_zero_oe_n_o) else $error("pin B not released");
  chk_lvr_copy: assert property (wr_at(8'hac) |-> ##2
    low_voltage_reset_enable_o == $past(wb_dat_i[7], 2)) else $error("lvr copy wrong");
  cov_read: cover property (wb_ack_o && !wb_we_i);
  cov_a_high: cover property (!port_three_bit_six_oe_n_o && port_three_bit_six_o);
  cov_b_high: cover property (!port_two_bit_zero_oe_n_o && port_two_bit_zero_o);
endmodule

bind dual_channel_pwm_unit pwm_properties pwm_properties_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .port_three_bit_six_o, .port_three_bit_six_oe_n_o, .port_two_bit_zero_o,
  .port_two_bit_zero_oe_n_o, .low_voltage_reset_enable_o);

//--- tb_dual_channel_pwm_unit.sv
module tb_dual_channel_pwm_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import pulse_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic ack, pa, na, pb, nb, low_voltage_reset_enable, la, lb;
  int ha, hb, n_errors = 0, comparisons = 0;
  byte_t q;
  // ****************************************************************
  // Register rows: address, write value, read-back value
  // ****************************************************************
  byte_t ra[5] = '{8'hac, 8'h98, 8'h9c, 8'h94, 8'ha0};
  byte_t rw[5] = '{8'hff, 8'h5a, 8'ha5, 8'h77, 8'hff};
  byte_t rx[5] = '{8'h81, 8'h5a, 8'ha5, 8'h77, 8'h00};
  dual_channel_pwm_unit dual_channel_pwm_unit_i (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port_three_bit_six_o(pa),
    .port_three_bit_six_oe_n_o(na), .port_two_bit_zero_o(pb),
    .port_two_bit_zero_oe_n_o(nb), .low_voltage_reset_enable_o(low_voltage_reset_enable));
  pin_load pin_load_a_i (.clk_i, .clr_i(clr), .drv_i(pa), .oe_n_i(na), .level_o(la),
    .highs_o(ha));
  pin_load pin_load_b_i (.clk_i, .clr_i(clr), .drv_i(pb), .oe_n_i(nb), .level_o(lb),
    .highs_o(hb));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled; a stuck slave is left to the watchdog
  task automatic bus(input byte_t a, input logic w, input logic [3:0] s, input byte_t d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, 24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    bus(a, 1'b1, 4'h1, d);
  endtask
  // Window of n+1 samples of driven-high cycles on both pins
  task automatic meas(input int n);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock and a watchdog sized well above the few thousand cycles needed
  initial forever #20 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(na, 1);
    foreach (ra[i]) begin
      bus(ra[i], 1'b0, 4'h1, 8'h00);
      chk(q, 8'h00);
    end
    foreach (ra[i]) begin
      wr(ra[i], rw[i]);
      bus(ra[i], 1'b0, 4'h1, 8'h00);
      chk(q, rx[i]);
    end
    bus(8'h98, 1'b1, 4'h2, 8'h11);
    bus(8'h98, 1'b0, 4'h1, 8'h00);
    chk(q, 8'h5a);
    $display("done registers");
    // Both channels narrow; B at a quarter clock, so one B period fills the window
    wr(8'h94, 8'h00);
    wr(8'hac, 8'h80);
    wr(8'h98, 8'h40);
    chk(low_voltage_reset_enable, 1);
    wr(8'h9c, 8'hc0);
    wr(8'h94, 8'h98);
    meas(1023);
    chk(ha, 256);
    chk(hb, 768);
    $display("done narrow");
    // One-tick pulse per prescale code, timed from a fresh enable
    wr(8'h94, 8'h00);
    wr(8'h98, 8'h01);
    for (int p = 0; p < 8; p++) begin
      wr(8'h94, byte_t'(8 | p));
      meas((4 << p) + 4);
      chk(ha, 2 << p);
      wr(8'h94, 8'h00);
    end
    // The enable register lands one edge before the pin enable; look once both settle
    @(negedge clk_i);
    chk(la, 1);
    $display("done prescale");
    // Wide mode: swapped bytes or a narrow period would both miss the count
    // Low voltage reset bit set too, so the mid-run reset has something to clear
    wr(8'hac, 8'h81);
    wr(8'h9c, 8'h01);
    wr(8'h98, 8'h02);
    wr(8'h94, 8'h88);
    meas(1199);
    chk(ha, 516);
    chk(nb, 1);
    chk(hb, 0);
    $display("done wide");
    // Second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(8'h94, 1'b0, 4'h1, 8'h00);
    chk(q, 8'h00);
    chk(na, 1);
    chk(low_voltage_reset_enable, 0);
    $display("done reset");
    // Duty rewritten mid-period must wait for the wrap: old duty gives 128 minus 2 unseen
    wr(8'h98, 8'h40);
    wr(8'h94, 8'h08);
    wr(8'h98, 8'hc0);
    meas(400);
    chk(ha, 126);
    $display("done update");
    end_of_test;
  end
endmodule
